// File: rtl/mss_pkg.sv
// mss_pkg: constants, register map and state types for the motor stop-mode sequencer.
// assumes a 125 MHz control tick; frequencies in 0.01 Hz units, times in 0.01 s units.
package mss_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int FREQ_W = 16;
    localparam int LVL_W = 8;
    localparam int TIME_W = 16;
    // one hundredth of a second in nanoseconds
    localparam int CENTISEC_NS = 10000000;
    localparam int CLK_NS = 8;
    localparam int TICKS_PER_CS = CENTISEC_NS / CLK_NS;
    // stop-method codes
    localparam logic [2:0] STOP_RAMP = 3'h0;
    localparam logic [2:0] STOP_DCBRAKE = 3'h1;
    localparam logic [2:0] STOP_COAST = 3'h2;
    localparam logic [2:0] STOP_POWER = 3'h4;
    // register offsets (word index on the plain port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_BLOCK_TIME = 4'h1;
    localparam logic [3:0] REG_INJ_TIME = 4'h2;
    localparam logic [3:0] REG_INJ_LEVEL = 4'h3;
    localparam logic [3:0] REG_INJ_FREQ = 4'h4;
    localparam logic [3:0] REG_DWELL_FREQ = 4'h5;
    localparam logic [3:0] REG_PROT = 4'h6;
    localparam logic [3:0] REG_BUS_LIMIT = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_FREQ = 4'h9;
    // control and protection field positions
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_METHOD_MSB = 2;
    localparam int PROT_STALL_BIT = 3;
    // reset values
    localparam logic [TIME_W-1:0] RST_BLOCK_TIME = 16'h000a; // 0.10 s
    localparam logic [TIME_W-1:0] RST_INJ_TIME = 16'h0064; // 1.00 s
    localparam logic [LVL_W-1:0] RST_INJ_LEVEL = 8'h32; // 50 %
    localparam logic [FREQ_W-1:0] RST_INJ_FREQ = 16'h01f4; // 5.00 Hz
    localparam logic [FREQ_W-1:0] RST_BUS_LIMIT = 16'h0000;
    localparam logic [FREQ_W-1:0] ZERO_FREQ = 16'h0000;
    localparam logic [LVL_W-1:0] MAX_LEVEL = 8'hc8; // 200 %
    typedef enum logic [2:0] {
        MSS_RUN,
        MSS_DECEL,
        MSS_BLOCK,
        MSS_INJECT,
        MSS_STOPPED
    } mss_state_e;
endpackage : mss_pkg

// File: rtl/mss_timer_if.sv
// mss_timer_if: load/expire handshake between the sequencer and its centisecond timer.
// assumes both ends share clk_i.
`timescale 1ns/10ps
interface mss_timer_if;
    import mss_pkg::*;
    logic load;
    logic [TIME_W-1:0] count;
    logic run;
    logic done;
    modport ctl (output load, output count, output run, input done);
    modport tmr (input load, input count, input run, output done);
endinterface : mss_timer_if

// File: rtl/mss_timer.sv
// mss_timer: counts down a preset number of centiseconds, flags done at zero.
// assumes a free-running clk_i and async active-low reset.
`timescale 1ns/10ps
module mss_timer (
    input wire logic clk_i, // control tick
    input wire logic resetn_i, // async reset, active low
    mss_timer_if.tmr tif // load / run / done
);
    import mss_pkg::*;
    logic [TIME_W-1:0] left_r;
    logic [31:0] tick_r;
    wire logic tick_wrap = (tick_r == 32'(TICKS_PER_CS - 1));
    // prescaler and centisecond down-counter
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            left_r <= '0;
            tick_r <= '0;
        end
        else if (tif.load)
        begin
            left_r <= tif.count;
            tick_r <= '0;
        end
        else if (tif.run && left_r != '0)
        begin
            tick_r <= tick_wrap ? '0 : tick_r + 32'h1;
            if (tick_wrap)
                left_r <= left_r - 16'h1;
        end
    end
    // done looks at the count only: load is decoded from the next state, which is chosen from done
    assign tif.done = (left_r == '0);
endmodule : mss_timer

// File: rtl/mss_seq.sv
// mss_seq: stop-mode sequencer top with register port, ramp stepping and dc injection.
// assumes a ramp generator outside steps the frequency when freq_step_i pulses.
//
// How it works
// - ramp method 0 ramps output frequency to zero, then stops.
// - dc method decelerates, then injects once frequency reaches start frequency.
// - output stays blocked for the pre-brake block time before injection.
// - dc is supplied for the injection duration plus one tick, then braking ends.
// - injection current is regulated to the configured percent of rated current.
// - dwell below injection start frequency is skipped; braking starts at that frequency.
// - coast method 2 cuts output as soon as run goes off.
// - power method 4 reverses the ramp, stepping frequency up, when bus voltage is over threshold.
// - stall prevention and power braking act only while decelerating.
// - with stall bit 3 and power method, power braking overrides stall prevention.
`timescale 1ns/10ps
module mss_seq (
    input wire logic clk_i, // control tick
    input wire logic resetn_i, // async reset, active low
    input wire logic [3:0] addr_i, // register index
    input wire logic [31:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [31:0] rdata_o, // read data, cycle after rd_i
    input wire logic run_i, // run command level
    input wire logic freq_step_i, // one ramp step pulse
    input wire logic [mss_pkg::FREQ_W-1:0] bus_volt_i, // dc bus voltage
    input wire logic stall_req_i, // stall prevention request from current limit
    output logic [mss_pkg::FREQ_W-1:0] freq_o, // output frequency
    output logic out_en_o, // inverter output enabled
    output logic dc_inj_o, // dc injection active
    output logic [mss_pkg::LVL_W-1:0] inj_level_o, // injection current percent
    output logic decel_hold_o, // power braking: hold the ramp
    output logic reaccel_o, // power braking: reaccelerate
    output logic stall_act_o // stall prevention active
);
    import mss_pkg::*;
    mss_state_e state_r, state_nxt;
    logic [2:0] method_r;
    logic [TIME_W-1:0] block_time_r, inj_time_r;
    logic [LVL_W-1:0] inj_level_r;
    logic [FREQ_W-1:0] inj_freq_r, dwell_freq_r, bus_limit_r, freq_r, freq_nxt;
    logic [7:0] prot_r;
    logic [FREQ_W-1:0] target_r;
    logic [31:0] rd_mux_w;
    logic [31:0] rdata_r;
    mss_timer_if tif();

    mss_timer u_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tif(tif)
    );

    // the register map packs times and frequencies into 16 bits and the level into 8
    // other widths would misplace fields in the read data
    if (FREQ_W != 16 || TIME_W != 16 || LVL_W != 8)
    begin : g_width_check
        $error("mss_seq: unsupported field widths");
    end

    // clamp level to its legal span
    function automatic logic [LVL_W-1:0] clamp_lvl(input logic [31:0] v);
        clamp_lvl = (v[LVL_W-1:0] > MAX_LEVEL || v[31:LVL_W] != '0) ? MAX_LEVEL : v[LVL_W-1:0];
    endfunction : clamp_lvl

    // register writes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            method_r <= STOP_RAMP;
            block_time_r <= RST_BLOCK_TIME;
            inj_time_r <= RST_INJ_TIME;
            inj_level_r <= RST_INJ_LEVEL;
            inj_freq_r <= RST_INJ_FREQ;
            dwell_freq_r <= ZERO_FREQ;
            prot_r <= '0;
            bus_limit_r <= RST_BUS_LIMIT;
            target_r <= ZERO_FREQ;
        end
        else if (wr_i)
        begin
            case (addr_i)
                REG_CTRL: method_r <= wdata_i[CTRL_METHOD_MSB:CTRL_METHOD_LSB];
                REG_BLOCK_TIME: block_time_r <= wdata_i[TIME_W-1:0];
                REG_INJ_TIME: inj_time_r <= wdata_i[TIME_W-1:0];
                REG_INJ_LEVEL: inj_level_r <= clamp_lvl(wdata_i);
                REG_INJ_FREQ: inj_freq_r <= wdata_i[FREQ_W-1:0];
                REG_DWELL_FREQ: dwell_freq_r <= wdata_i[FREQ_W-1:0];
                REG_PROT: prot_r <= wdata_i[7:0];
                REG_BUS_LIMIT: bus_limit_r <= wdata_i[FREQ_W-1:0];
                REG_FREQ: target_r <= wdata_i[FREQ_W-1:0];
                default: ;
            endcase
        end
    end

    // read mux on the requested index
    wire logic [31:0] status_w = {24'h0, 1'b0, stall_act_o, reaccel_o, dc_inj_o, out_en_o, state_r};
    always_comb
    begin
        rd_mux_w = '0;
        case (addr_i)
            REG_CTRL: rd_mux_w = {29'h0, method_r};
            REG_BLOCK_TIME: rd_mux_w = {16'h0, block_time_r};
            REG_INJ_TIME: rd_mux_w = {16'h0, inj_time_r};
            REG_INJ_LEVEL: rd_mux_w = {24'h0, inj_level_r};
            REG_INJ_FREQ: rd_mux_w = {16'h0, inj_freq_r};
            REG_DWELL_FREQ: rd_mux_w = {16'h0, dwell_freq_r};
            REG_PROT: rd_mux_w = {24'h0, prot_r};
            REG_BUS_LIMIT: rd_mux_w = {16'h0, bus_limit_r};
            REG_STATUS: rd_mux_w = status_w;
            REG_FREQ: rd_mux_w = {16'h0, freq_r};
            default: rd_mux_w = '0;
        endcase
    end
    // read data flop: holds the answer only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_r <= '0;
        else
            rdata_r <= rd_i ? rd_mux_w : '0;
    end
    assign rdata_o = rdata_r;

    // decoded conditions
    wire logic decel_w = (state_r == MSS_DECEL);
    wire logic over_volt_w = (method_r == STOP_POWER) && decel_w && (bus_volt_i > bus_limit_r);
    wire logic stall_en_w = prot_r[PROT_STALL_BIT] && decel_w && stall_req_i && !over_volt_w;
    wire logic dwell_skip_w = (dwell_freq_r < inj_freq_r);
    // dc start point: dwell at or above start freq is passed before braking begins
    wire logic [FREQ_W-1:0] inj_thr_w = inj_freq_r;
    wire logic at_inj_w = (method_r == STOP_DCBRAKE) && (freq_r <= inj_thr_w)
        && (dwell_skip_w || freq_r < dwell_freq_r);
    wire logic at_zero_w = (freq_r == ZERO_FREQ);

    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            MSS_STOPPED:
                if (run_i)
                    state_nxt = MSS_RUN;
            MSS_RUN:
                if (!run_i)
                begin
                    if (method_r == STOP_COAST)
                        state_nxt = MSS_STOPPED;
                    else
                        state_nxt = MSS_DECEL;
                end
            MSS_DECEL:
                if (run_i)
                    state_nxt = MSS_RUN;
                else if (at_inj_w)
                    state_nxt = MSS_BLOCK;
                else if (at_zero_w)
                    state_nxt = MSS_STOPPED;
            MSS_BLOCK:
                if (tif.done)
                    state_nxt = MSS_INJECT;
            MSS_INJECT:
                if (tif.done)
                    state_nxt = MSS_STOPPED;
            default: state_nxt = MSS_STOPPED;
        endcase
    end

    // timer loads on entry to block and inject
    // the load is a decode of the next state, so it fires once per phase entry
    assign tif.load = (state_r != state_nxt) && (state_nxt == MSS_BLOCK || state_nxt == MSS_INJECT);
    assign tif.count = (state_nxt == MSS_BLOCK) ? block_time_r : inj_time_r;
    assign tif.run = (state_r == MSS_BLOCK) || (state_r == MSS_INJECT);

    // frequency stepping
    always_comb
    begin
        freq_nxt = freq_r;
        case (state_r)
            MSS_RUN:
                if (freq_step_i && freq_r < target_r)
                    freq_nxt = freq_r + 16'h1;
                else if (freq_step_i && freq_r > target_r)
                    freq_nxt = freq_r - 16'h1;
            MSS_DECEL:
                if (over_volt_w && freq_step_i)
                    freq_nxt = freq_r + 16'h1;
                else if (freq_step_i && !stall_en_w && !at_zero_w)
                    freq_nxt = freq_r - 16'h1;
            MSS_STOPPED, MSS_BLOCK, MSS_INJECT: freq_nxt = ZERO_FREQ;
            default: freq_nxt = ZERO_FREQ;
        endcase
        if (state_r == MSS_RUN && !run_i && method_r == STOP_COAST)
            freq_nxt = ZERO_FREQ;
    end

    // state and frequency registers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r <= MSS_STOPPED;
            freq_r <= ZERO_FREQ;
        end
        else
        begin
            state_r <= state_nxt;
            freq_r <= freq_nxt;
        end
    end

    // outputs
    assign freq_o = freq_r;
    assign out_en_o = (state_r == MSS_RUN) || (state_r == MSS_DECEL);
    assign dc_inj_o = (state_r == MSS_INJECT);
    assign inj_level_o = dc_inj_o ? inj_level_r : '0;
    assign decel_hold_o = over_volt_w;
    assign reaccel_o = over_volt_w;
    assign stall_act_o = stall_en_w;

    // checks
    sequence s_block_done;
        (state_r == MSS_BLOCK) ##1 (state_r == MSS_INJECT);
    endsequence
    chk_coast_cuts_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_RUN && !run_i && method_r == STOP_COAST) |=> !out_en_o && freq_o == ZERO_FREQ)
        else $error("coast did not cut output");
    chk_inject_after_block: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(dc_inj_o) |-> $past(state_r) == MSS_BLOCK)
        else $error("injection without block");
    chk_block_no_output: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_BLOCK) |-> !out_en_o && !dc_inj_o)
        else $error("output during block");
    chk_inject_level: assert property (@(posedge clk_i) disable iff (!resetn_i)
        dc_inj_o |-> inj_level_o == inj_level_r && inj_level_o <= MAX_LEVEL)
        else $error("wrong injection level");
    chk_inject_ends_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(dc_inj_o) |-> state_r == MSS_STOPPED && !out_en_o)
        else $error("injection did not end in stop");
    chk_power_only_decel: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reaccel_o || stall_act_o) |-> state_r == MSS_DECEL)
        else $error("braking aid outside decel");
    chk_power_over_stall: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reaccel_o |-> !stall_act_o)
        else $error("stall active with power braking");
    chk_dc_start_freq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_DECEL ##1 state_r == MSS_BLOCK) |-> $past(freq_r) <= inj_freq_r)
        else $error("braking began above start freq");
    chk_ramp_stop_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_DECEL ##1 state_r == MSS_STOPPED) |-> $past(freq_r) == ZERO_FREQ)
        else $error("ramp stop above zero");
    chk_block_seq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_block_done |-> dc_inj_o)
        else $error("block not followed by injection");
    // zero block or injection time leaves each phase exactly one tick long
    sequence s_enter_block;
        (state_r == MSS_DECEL) ##1 (state_r == MSS_BLOCK);
    endsequence
    chk_block_zero_time: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_enter_block ##0 (block_time_r == '0)) |=> state_r == MSS_INJECT)
        else $error("zero block time not one tick");
    chk_inject_zero_time: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_block_done ##0 (inj_time_r == '0)) |=> state_r == MSS_STOPPED)
        else $error("zero injection time not one tick");
    // a dwell below the start frequency never delays the block phase
    chk_dwell_skipped: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_DECEL && !run_i && method_r == STOP_DCBRAKE && dwell_freq_r < inj_freq_r
        && freq_o <= inj_freq_r) |=> state_r == MSS_BLOCK)
        else $error("dwell not skipped at start freq");
    // the frequency moves one step down, one step up or not at all, by the aid in force
    chk_ramp_step_down: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_DECEL && freq_step_i && !reaccel_o && !stall_act_o && freq_o != ZERO_FREQ)
        |=> freq_o == $past(freq_o) - 16'h1)
        else $error("decel step missed");
    chk_reaccel_climbs: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reaccel_o && freq_step_i) |=> freq_o == $past(freq_o) + 16'h1)
        else $error("power braking did not reaccelerate");
    chk_stall_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
        stall_act_o |=> freq_o == $past(freq_o))
        else $error("frequency moved during stall hold");
    // the ramp method stops only from zero, and a stopped drive takes a new run
    chk_ramp_ends_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_DECEL && !run_i && method_r == STOP_RAMP && freq_o == ZERO_FREQ)
        |=> state_r == MSS_STOPPED && freq_o == ZERO_FREQ)
        else $error("ramp stop did not stop at zero");
    chk_stop_takes_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == MSS_STOPPED && run_i) |=> state_r == MSS_RUN && out_en_o)
        else $error("stopped drive ignored run");
    // injection current is bounded and present only while injecting
    chk_level_bounded: assert property (@(posedge clk_i) disable iff (!resetn_i)
        inj_level_r <= MAX_LEVEL)
        else $error("injection level above limit");
    chk_level_idle_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !dc_inj_o |-> inj_level_o == '0)
        else $error("injection level outside injection");
    // read data stand only in the cycle after a read strobe
    chk_rdata_idle_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$past(rd_i) |-> rdata_o == '0)
        else $error("read data without read strobe");
endmodule : mss_seq

// File: tb/mss_motor_model.sv
// mss_motor_model: power stage and ramp source in front of the stop-mode sequencer.
// assumes the sequencer's clk_i; the bench decides when regeneration lifts the bus.
`timescale 1ns/10ps
module mss_motor_model (
    input wire logic clk_i, // control tick
    input wire logic resetn_i, // async reset, active low
    input wire logic out_en_i, // inverter output on
    input wire logic regen_i, // bench asks for regenerated energy
    output logic freq_step_o, // one ramp step pulse
    output logic [mss_pkg::FREQ_W-1:0] bus_volt_o // dc bus voltage
);
    import mss_pkg::*;
    logic phase_r;
    // one step every other tick, only while the output drives the motor
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            phase_r <= 1'b0;
        end
        else
        begin
            phase_r <= out_en_i ? ~phase_r : 1'b0;
        end
    end
    assign freq_step_o = phase_r;
    // bus rises well above the limit while regenerating
    assign bus_volt_o = regen_i ? 16'h0200 : 16'h0040;
endmodule : mss_motor_model

// File: tb/tb_top.sv
// tb_top: register-port bench for the stop-mode sequencer, one scenario per stop method plus a stall-prevention ramp stop.
// assumes zero block and injection times, so each of those phases lasts one tick.
`timescale 1ns/10ps
module tb_top;
    import mss_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic run_i = 1'b0;
    logic stall_req_i = 1'b0;
    logic regen = 1'b0;
    logic freq_step;
    logic [FREQ_W-1:0] bus_volt;
    logic [31:0] rdata_o;
    logic [FREQ_W-1:0] freq_o;
    logic [LVL_W-1:0] inj_level_o;
    logic out_en_o, dc_inj_o, decel_hold_o, reaccel_o, stall_act_o;
    logic [FREQ_W-1:0] last_freq = 16'h0;
    logic [31:0] d;
    int n;
    int num_errors = 0;
    int samples_checked = 0;
    always #4 clk_i = ~clk_i;
    mss_seq mss_seq_inst (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .run_i(run_i), .freq_step_i(freq_step),
        .bus_volt_i(bus_volt), .stall_req_i(stall_req_i), .freq_o(freq_o), .out_en_o(out_en_o),
        .dc_inj_o(dc_inj_o), .inj_level_o(inj_level_o), .decel_hold_o(decel_hold_o),
        .reaccel_o(reaccel_o), .stall_act_o(stall_act_o));
    mss_motor_model mss_motor_model_inst (.clk_i(clk_i), .resetn_i(resetn_i), .out_en_i(out_en_o),
        .regen_i(regen), .freq_step_o(freq_step), .bus_volt_o(bus_volt));
    // frequency seen in the last tick the output was still on
    always @(posedge clk_i)
    begin
        if (out_en_o === 1'b1)
            last_freq <= freq_o;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tick;
        @(posedge clk_i);
        #1;
    endtask : tick
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd
    // poll the status state field until it matches, bounded
    task wait_st(input mss_state_e st);
        n = 0;
        do
        begin
            rd(REG_STATUS, d);
            n++;
        end
        while (d[2:0] !== st && n < 3000);
    endtask : wait_st
    // start a run under the given method, reach the target, then drop run
    task go(input logic [2:0] m);
        wr(REG_CTRL, {29'h0, m});
        @(posedge clk_i);
        run_i <= 1'b1;
        n = 0;
        while (freq_o !== 16'h0064 && n < 3000)
        begin
            tick();
            n++;
        end
        rd(REG_FREQ, d);
        check(d, 32'h00000064);
        rd(REG_STATUS, d);
        check(d[3:0], {1'b1, MSS_RUN});
        check({decel_hold_o, reaccel_o, stall_act_o}, 3'h0);
        @(posedge clk_i);
        run_i <= 1'b0;
    endtask : go
    task finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    // watchdog cuts a hang well beyond the few thousand ticks the tests need
    initial
    begin
        #400000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(REG_BLOCK_TIME, d);
        check(d, 32'h0000000a);
        rd(REG_INJ_TIME, d);
        check(d, 32'h00000064);
        rd(REG_INJ_LEVEL, d);
        check(d, 32'h00000032);
        rd(REG_INJ_FREQ, d);
        check(d, 32'h000001f4);
        rd(4'hf, d);
        check(d, 32'h0);
        rd(REG_STATUS, d);
        check(d[2:0], MSS_STOPPED);
        wr(REG_INJ_LEVEL, 32'hff);
        rd(REG_INJ_LEVEL, d);
        check(d, 32'h000000c8);
        wr(REG_INJ_LEVEL, 32'h50);
        wr(REG_BLOCK_TIME, 32'h0);
        wr(REG_INJ_TIME, 32'h0);
        wr(REG_INJ_FREQ, 32'h32);
        wr(REG_DWELL_FREQ, 32'h0a);
        wr(REG_BUS_LIMIT, 32'h100);
        wr(REG_FREQ, 32'h64);
        $display("test setup done");
        go(STOP_RAMP);
        wait_st(MSS_STOPPED);
        check(d[3:0], {1'b0, MSS_STOPPED});
        check(freq_o, 16'h0);
        $display("test ramp stop done");
        go(STOP_DCBRAKE);
        n = 0;
        while (out_en_o !== 1'b0 && n < 3000)
        begin
            tick();
            n++;
        end
        check(last_freq >= 16'h0031 && last_freq <= 16'h0032, 1'b1);
        n = 0;
        while (dc_inj_o !== 1'b1 && n < 100)
        begin
            tick();
            n++;
        end
        check(n, 1);
        check(inj_level_o, 8'h50);
        n = 0;
        while (dc_inj_o === 1'b1 && n < 100)
        begin
            tick();
            n++;
        end
        check(n, 1);
        check(out_en_o, 1'b0);
        rd(REG_STATUS, d);
        check(d[2:0], MSS_STOPPED);
        $display("test dc brake done");
        go(STOP_COAST);
        tick();
        check({out_en_o, freq_o}, 17'h0);
        $display("test coast done");
        wr(REG_PROT, 32'h8);
        regen <= 1'b1;
        stall_req_i <= 1'b1;
        go(STOP_POWER);
        repeat (4) tick();
        check(decel_hold_o | reaccel_o, 1'b1);
        check(freq_o > 16'h0064, 1'b1);
        check(stall_act_o, 1'b0);
        @(posedge clk_i);
        regen <= 1'b0;
        repeat (2) tick();
        check(stall_act_o, 1'b1);
        @(posedge clk_i);
        stall_req_i <= 1'b0;
        wait_st(MSS_STOPPED);
        check(d[2:0], MSS_STOPPED);
        $display("test power braking done");
        go(STOP_RAMP);
        stall_req_i <= 1'b1;
        repeat (4) tick();
        check(stall_act_o, 1'b1);
        check(freq_o, 16'h0064);
        @(posedge clk_i);
        stall_req_i <= 1'b0;
        wait_st(MSS_STOPPED);
        check(d[2:0], MSS_STOPPED);
        $display("test stall decel done");
        finish_test();
    end
endmodule : tb_top
